// [rtl/epo_pkg.sv]
/*
 Package for the energy pulse output block: register map, field widths,
 reset values and timing constants.
 Assumes a 25 MHz system clock and an APB register port with 32-bit data.
*/
package epo_pkg;
   // Channel count and order
   localparam int CHANNELS          = 4;
   localparam int CH_ACT_EXPORT     = 0;
   localparam int CH_REACT_EXPORT   = 1;
   localparam int CH_ACT_IMPORT     = 2;
   localparam int CH_REACT_IMPORT   = 3;

   // Clock and time base
   localparam int CLK_HZ            = 25000000;
   localparam int MS_PER_S          = 1000;
   localparam int TICK_MS           = 1;
   localparam int CYCLES_PER_MS     = CLK_HZ / MS_PER_S * TICK_MS;

   // Setting limits
   localparam logic [15:0] QUANTUM_MIN = 16'h000A;
   localparam logic [15:0] QUANTUM_MAX = 16'h2710;
   localparam logic [15:0] LENGTH_MIN  = 16'h0064;
   localparam logic [15:0] LENGTH_MAX  = 16'h1388;
   localparam logic [15:0] QUANTUM_RST = 16'h000A;
   localparam logic [15:0] LENGTH_RST  = 16'h0064;

   // Field widths
   localparam int SET_W             = 16;
   localparam int ACC_W             = 32;
   localparam int OUT_W             = 8;

   // Register map, byte addresses
   localparam logic [7:0] ADDR_QUANTUM_BASE = 8'h00;
   localparam logic [7:0] ADDR_LENGTH_BASE  = 8'h10;
   localparam logic [7:0] ADDR_ROUTE_BASE   = 8'h20;
   localparam logic [7:0] ADDR_STATUS       = 8'h30;
   localparam logic [7:0] ADDR_ACC_BASE     = 8'h40;
   localparam logic [7:0] ADDR_CTRL         = 8'h50;
   localparam int         ADDR_W            = 8;
   localparam int         CTRL_ENABLE_BIT   = 0;
   localparam int         CTRL_CLEAR_BIT    = 1;
   localparam logic [31:0] CTRL_RST         = 32'h0000_0001;
endpackage

// [rtl/epo_channel.sv]
/*
 One energy pulse channel: accumulates energy increments, fires a pulse
 when the quantum is reached and times the pulse in milliseconds.
 Assumes a one-cycle millisecond enable and settings that are in range.
*/
module epo_channel #(
   parameter int SET_W = epo_pkg::SET_W,
   parameter int ACC_W = epo_pkg::ACC_W
) (
   input  wire logic             clk,        // System clock
   input  wire logic             reset_n,    // Async reset, active low
   input  wire logic             enable,     // Channel counting enable
   input  wire logic             clear,      // Clear accumulator and pulse
   input  wire logic             ms_tick,    // One-cycle millisecond enable
   input  wire logic             energy_inc, // Energy increment valid
   input  wire logic [SET_W-1:0] energy_amt, // Increment in energy units
   input  wire logic [SET_W-1:0] quantum,    // Pulse quantum
   input  wire logic [SET_W-1:0] length_ms,  // Pulse length in ms
   output logic                  pulse,      // Pulse output level
   output logic      [ACC_W-1:0] accum       // Accumulated remainder
);
   typedef struct packed {
      logic [ACC_W-1:0] acc;
      logic [SET_W-1:0] left;
      logic [SET_W-1:0] owed;
      logic             active;
   } epo_ch_state_type;

   epo_ch_state_type state_reg;
   epo_ch_state_type state_next;

   // Accumulate, pulse start and pulse timing
   always_comb begin
      logic [ACC_W-1:0] sum;
      sum = '0;
      state_next = state_reg;
      sum = state_reg.acc;
      if (enable && energy_inc) begin
         sum = state_reg.acc + ACC_W'(energy_amt);
      end
      if (sum >= ACC_W'(quantum)) begin                      // RULE2
         sum = sum - ACC_W'(quantum);                         // RULE8
         state_next.owed = state_reg.owed + 1'b1;
      end
      state_next.acc = sum;
      if (state_reg.active) begin
         if (ms_tick) begin
            if (state_reg.left == SET_W'(1)) begin            // RULE3
               state_next.active = 1'b0;
            end else begin
               state_next.left = state_reg.left - 1'b1;
            end
         end
      end else if (state_reg.owed != '0) begin                // RULE2
         state_next.active = 1'b1;
         state_next.left   = length_ms;                       // RULE3
         state_next.owed   = state_next.owed - 1'b1;
      end
      if (clear) begin
         state_next = '0;
      end
   end

   // State register
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign pulse = state_reg.active;
   assign accum = state_reg.acc;
endmodule

// [rtl/epo_top.sv]
/*
 Energy pulse outputs: four pulse channels with APB-set quanta, lengths and
 an output routing matrix onto the digital outputs.
 Assumes energy increments from measurement logic on the same clock.
*/
// Register access over APB and the address map were left to the implementer.
// Contract
// RULE1 - There are four independent pulse channels, one per energy direction.
// RULE2 - A channel starts a pulse each time its energy reaches its quantum.
// RULE3 - A started pulse lasts exactly its configured length, then ends; the code ends it on the length-th ms tick, after length-1 to length ms.
// RULE4 - Each channel has its own quantum setting from 10 to 10000 units.
// RULE5 - Each channel has its own pulse length from 100 to 5000 ms.
// RULE6 - Any channel can drive any set of digital outputs via a matrix.
// RULE7 - Software should keep length below peak pulse period minus 0.2 s.
// RULE8 - After a pulse the quantum is subtracted and the remainder kept.
module epo_top #(
   parameter int OUT_W = epo_pkg::OUT_W
) (
   input  wire logic                                   clk,        // Clock
   input  wire logic                                   reset_n,    // Reset
   input  wire logic                                   psel,       // APB
   input  wire logic                                   penable,    // APB
   input  wire logic                                   pwrite,     // APB
   input  wire logic [epo_pkg::ADDR_W-1:0]             paddr,      // APB
   input  wire logic [31:0]                            pwdata,     // APB
   output logic      [31:0]                            prdata,     // APB
   output logic                                        pready,     // APB
   output logic                                        pslverr,    // APB
   input  wire logic [epo_pkg::CHANNELS-1:0]           energy_inc, // Valid
   input  wire logic [epo_pkg::CHANNELS*epo_pkg::SET_W-1:0] energy_amt,
   output logic      [epo_pkg::CHANNELS-1:0]           pulse_out,  // Pulses
   output logic      [OUT_W-1:0]                       dig_out     // Outputs
);
   localparam int CH = epo_pkg::CHANNELS;
   localparam int SW = epo_pkg::SET_W;
   localparam int MSW = $clog2(epo_pkg::CYCLES_PER_MS);

   typedef struct packed {
      logic [CH-1:0][SW-1:0]    quantum;
      logic [CH-1:0][SW-1:0]    length;
      logic [CH-1:0][OUT_W-1:0] route;
      logic [31:0]              ctrl;
      logic [MSW-1:0]           ms_cnt;
      logic                     ms_tick;
      logic [31:0]              rdata;
      logic                     err;
      logic [OUT_W-1:0]         dout;
      logic                     ack;
   } epo_state_type;

   epo_state_type state_reg;
   epo_state_type state_next;

   logic [CH-1:0]                       pulse;
   logic [CH-1:0][epo_pkg::ACC_W-1:0]   accum;
   logic                                clear_pulse;

   // Clamp a setting into its legal range
   function automatic logic [SW-1:0] clamp(input logic [31:0] v,
                                           input logic [SW-1:0] lo,
                                           input logic [SW-1:0] hi);
      if (v < 32'(lo)) begin
         return lo;
      end else if (v > 32'(hi)) begin
         return hi;
      end
      return v[SW-1:0];
   endfunction

   // Word index within a bank of four registers
   function automatic logic [1:0] idx(input logic [epo_pkg::ADDR_W-1:0] a);
      return a[3:2];
   endfunction

   // One wait state so that registered read data stands with pready
   assign pready      = state_reg.ack;
   assign prdata      = state_reg.rdata;
   assign pslverr     = state_reg.err;
   assign pulse_out   = pulse;
   assign dig_out     = state_reg.dout;
   assign clear_pulse = psel && penable && pwrite && state_reg.ack
                        && paddr == epo_pkg::ADDR_CTRL
                        && pwdata[epo_pkg::CTRL_CLEAR_BIT];

   // Millisecond divider, APB access and routing matrix
   always_comb begin
      logic [epo_pkg::ADDR_W-1:0] bank;
      logic                       hit;
      logic [OUT_W-1:0]           d;
      bank = '0;
      hit  = 1'b0;
      d    = '0;
      state_next = state_reg;
      state_next.ms_tick = 1'b0;
      if (state_reg.ms_cnt == MSW'(epo_pkg::CYCLES_PER_MS - 1)) begin
         state_next.ms_cnt  = '0;
         state_next.ms_tick = 1'b1;
      end else begin
         state_next.ms_cnt = state_reg.ms_cnt + 1'b1;
      end
      bank = {paddr[epo_pkg::ADDR_W-1:4], 4'h0};
      hit = paddr[1:0] == 2'h0 && (bank == epo_pkg::ADDR_QUANTUM_BASE
            || bank == epo_pkg::ADDR_LENGTH_BASE
            || bank == epo_pkg::ADDR_ROUTE_BASE
            || bank == epo_pkg::ADDR_ACC_BASE
            || paddr == epo_pkg::ADDR_STATUS
            || paddr == epo_pkg::ADDR_CTRL);
      // First access cycle latches the answer, second one completes
      state_next.ack = psel && penable && !state_reg.ack;
      if (psel && penable && state_reg.ack && pwrite && hit) begin
            if (bank == epo_pkg::ADDR_QUANTUM_BASE) begin
               state_next.quantum[idx(paddr)] = clamp(pwdata,
                  epo_pkg::QUANTUM_MIN, epo_pkg::QUANTUM_MAX);  // RULE4
            end else if (bank == epo_pkg::ADDR_LENGTH_BASE) begin
               state_next.length[idx(paddr)] = clamp(pwdata,
                  epo_pkg::LENGTH_MIN, epo_pkg::LENGTH_MAX);    // RULE5
            end else if (bank == epo_pkg::ADDR_ROUTE_BASE) begin
               state_next.route[idx(paddr)] = pwdata[OUT_W-1:0];
            end else if (paddr == epo_pkg::ADDR_CTRL) begin
               state_next.ctrl = 32'(pwdata[epo_pkg::CTRL_ENABLE_BIT]);
            end
      end
      if (psel && penable && !state_reg.ack) begin
         state_next.err   = !hit;
         state_next.rdata = '0;
         if (!pwrite && hit) begin
            if (bank == epo_pkg::ADDR_QUANTUM_BASE) begin
               state_next.rdata = 32'(state_reg.quantum[idx(paddr)]);
            end else if (bank == epo_pkg::ADDR_LENGTH_BASE) begin
               state_next.rdata = 32'(state_reg.length[idx(paddr)]);
            end else if (bank == epo_pkg::ADDR_ROUTE_BASE) begin
               state_next.rdata = 32'(state_reg.route[idx(paddr)]);
            end else if (bank == epo_pkg::ADDR_ACC_BASE) begin
               state_next.rdata = accum[idx(paddr)];
            end else if (paddr == epo_pkg::ADDR_STATUS) begin
               state_next.rdata = 32'(pulse);
            end else begin
               state_next.rdata = state_reg.ctrl;
            end
         end
      end
      // Each output is the OR of the channels routed to it
      for (int c = 0; c < CH; c++) begin
         if (pulse[c]) begin
            d = d | state_reg.route[c];                          // RULE6
         end
      end
      state_next.dout = d;
   end

   // State register
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg         <= '0;
         state_reg.quantum <= {CH{epo_pkg::QUANTUM_RST}};
         state_reg.length  <= {CH{epo_pkg::LENGTH_RST}};
         state_reg.ctrl    <= epo_pkg::CTRL_RST;
      end else begin
         state_reg <= state_next;
      end
   end

   // Four independent channels
   for (genvar c = 0; c < CH; c++) begin : g_ch
      epo_channel u_ch (                                         // RULE1
         .clk        (clk),
         .reset_n    (reset_n),
         .enable     (state_reg.ctrl[epo_pkg::CTRL_ENABLE_BIT]),
         .clear      (clear_pulse),
         .ms_tick    (state_reg.ms_tick),
         .energy_inc (energy_inc[c]),
         .energy_amt (energy_amt[c*SW +: SW]),
         .quantum    (state_reg.quantum[c]),
         .length_ms  (state_reg.length[c]),
         .pulse      (pulse[c]),
         .accum      (accum[c])
      );
   end
endmodule

// [bench/epo_top_sva.sv]
/*
 Checker for the energy pulse output block, bound to epo_top.
 Assumes one 25 MHz clock and an APB slave answering after one wait state.
*/
module epo_top_sva #(
   parameter int OUT_W = 8
) (
   input wire logic                          clk,       // Clock
   input wire logic                          reset_n,   // Reset
   input wire logic                          psel,      // APB
   input wire logic                          penable,   // APB
   input wire logic                          pwrite,    // APB
   input wire logic [epo_pkg::ADDR_W-1:0]    paddr,     // APB
   input wire logic [31:0]                   pwdata,    // APB
   input wire logic [31:0]                   prdata,    // APB
   input wire logic                          pslverr,   // APB
   input wire logic                          pready,    // APB
   input wire logic [epo_pkg::CHANNELS-1:0]  pulse_out, // Pulses
   input wire logic [OUT_W-1:0]              dig_out    // Outputs
);
   localparam int MIN_HI = 99 * epo_pkg::CYCLES_PER_MS;
   localparam int MAX_HI = 5001 * epo_pkg::CYCLES_PER_MS;
   logic        xfer;
   logic        first;
   logic        clr;
   logic [31:0] hi_cnt;
   logic        clr_seen;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   assign xfer  = psel & penable;
   assign first = xfer & !pready;
   assign clr   = xfer & pready & pwrite & (paddr == epo_pkg::ADDR_CTRL)
                  & pwdata[epo_pkg::CTRL_CLEAR_BIT];
   // Length of channel 0 pulse, and whether a clear cut it short
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         hi_cnt   <= '0;
         clr_seen <= 1'b0;
      end else begin
         hi_cnt   <= pulse_out[0] ? hi_cnt + 32'h1 : '0;
         clr_seen <= pulse_out[0] & (clr_seen | clr);
      end
   end
   property p_status;
      first && !pwrite && paddr == epo_pkg::ADDR_STATUS
         |=> prdata[3:0] == $past(pulse_out);
   endproperty
   a_status: assert property (p_status) else $error("status wrong");
   property p_route;
      pulse_out == '0 |=> dig_out == '0;
   endproperty
   a_route: assert property (p_route) else $error("stray output");
   property p_qrange;
      first && !pwrite && paddr < 8'h10 && paddr[1:0] == 2'h0
         |=> prdata >= 32'h000A
         && prdata <= 32'h2710;
   endproperty
   a_qrange: assert property (p_qrange) else $error("quantum range");
   property p_lrange;
      first && !pwrite && paddr inside {[8'h10:8'h1F]} && paddr[1:0] == 2'h0
         |=> prdata >= 32'h0064 && prdata <= 32'h1388;
   endproperty
   a_lrange: assert property (p_lrange) else $error("length range");
   property p_hi_min;
      $fell(pulse_out[0]) && !clr_seen |-> hi_cnt >= MIN_HI;
   endproperty
   a_hi_min: assert property (p_hi_min) else $error("pulse short");
   property p_hi_max;
      hi_cnt <= MAX_HI;
   endproperty
   a_hi_max: assert property (p_hi_max) else $error("pulse long");
   property p_slverr;
      first && paddr > epo_pkg::ADDR_CTRL |=> pslverr;
   endproperty
   a_slverr: assert property (p_slverr) else $error("no error");
   property p_clear;
      clr |-> ##[1:2] pulse_out == '0;
   endproperty
   a_clear: assert property (p_clear) else $error("clear ignored");
endmodule
bind epo_top epo_top_sva #(.OUT_W(OUT_W)) u_sva (.clk, .reset_n, .psel,
   .penable, .pwrite, .paddr, .pwdata, .prdata, .pslverr, .pready, .pulse_out,
   .dig_out);

// [bench/epo_pulse_counter.sv]
/*
 Model of the external controller counting pulses on the outputs.
 Assumes outputs that change just after the rising clock edge.
*/
module epo_pulse_counter #(
   parameter int OUT_W = 8
) (
   input wire logic             clk,     // Clock
   input wire logic             reset_n, // Reset
   input wire logic [OUT_W-1:0] dig_in,  // Pulse lines
   output int                   edges    // Pulses seen
);
   logic [OUT_W-1:0] last;
   // Counts rising edges on every line
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         last  <= '0;
         edges <= 0;
      end else begin
         edges <= edges + $countones(dig_in & ~last);
         last  <= dig_in;
      end
   end
endmodule

// [bench/epo_top_test.sv]
/*
 Self-checking bench for epo_top with an APB master and a pulse counter.
 Assumes the checker is bound from its own file.
*/
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
   $display("ERROR at %0t got %h exp %h", $time, a, b); end end
module epo_top_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk, reset_n, psel, penable, pwrite, pready, pslverr, e;
   logic [7:0]  paddr, dig_out;
   logic [31:0] pwdata, prdata, r, m, len;
   logic [3:0]  energy_inc, pulse_out;
   logic [63:0] energy_amt, amts;
   int          edges, error_cnt, n_checks, acc, amt, e0, q[4];
   bit          fired;
   int unsigned seed = 53094;
   epo_top DUT (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .energy_inc, .energy_amt, .pulse_out,
      .dig_out);
   epo_pulse_counter PC (.clk, .reset_n, .dig_in(dig_out), .edges);
   function int unsigned rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // One APB transfer; answer taken at the edge that samples pready high
   task apb(input bit w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      `CHK(r, x)
   endtask
   task stop_test();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Watchdog
   initial begin
      #(40 * 20000);
      error_cnt++;
      stop_test();
   end
   // Main sequence
   initial begin
      {reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
      energy_inc = '0;
      energy_amt = '0;
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         rd(8'(4 * i), 32'h000A);
         rd(8'(16 + 4 * i), 32'h0064);
         rd(8'(32 + 4 * i), 32'h0);
      end
      rd(8'h50, 32'h1);
      apb(1'b0, 8'h60, 32'h0);
      `CHK({e, r}, {1'b1, 32'h0})
      $display("test reset done");
      for (int c = 0; c < 4; c++) begin
         q[c] = (c == 0) ? 10 : 10 + int'(rnd() % 9991);
         apb(1'b1, 8'(4 * c), (c == 0) ? 32'h5 : 32'(q[c]));
         rd(8'(4 * c), 32'(q[c]));
         len = 32'(100 + rnd() % 4901);
         apb(1'b1, 8'(16 + 4 * c), len);
         rd(8'(16 + 4 * c), len);
         m = (rnd() & 32'hFF) | 32'h1;
         apb(1'b1, 8'(32 + 4 * c), m);
         apb(1'b1, 8'h50, 32'h3);
         acc = 0;
         fired = 1'b0;
         e0 = edges;
         while (!fired) begin
            amt = q[c] / 2 + int'(rnd() % (q[c] / 2));
            amts = {rnd(), rnd()};
            amts[16 * c +: 16] = 16'(amt);
            @(posedge clk);
            energy_amt <= amts;
            energy_inc <= 4'(1 << c);
            @(posedge clk);
            energy_inc <= '0;
            acc += amt;
            if (acc >= q[c]) begin
               acc -= q[c];
               fired = 1'b1;
            end
         end
         repeat (3) @(posedge clk);
         #1 `CHK(pulse_out, 4'(1 << c))
         `CHK(dig_out, m[7:0])
         `CHK(edges - e0, $countones(m[7:0]))
         rd(8'(64 + 4 * c), 32'(acc));
         rd(8'h30, 32'(1 << c));
         $display("test channel %0d done", c);
      end
      apb(1'b1, 8'h50, 32'h3);
      @(posedge clk);
      #1 `CHK(pulse_out, 4'h0)
      stop_test();
   end
endmodule
